/* File: hw/tcrit_hysteresis_and_id_regs.v */
// Common hysteresis and identification registers with critical outputs
`timescale 1ns/1ps
`include "tcrit_hyst_id_defines.vh"

// Limits, masks and temperatures arrive as plain inputs; the registers
// that hold them live elsewhere. Reads of unused commands return zero.
// A write and a read in one cycle: the read returns the old value.
// Identity codes are parameters so a new revision needs no code change.

module tcrit_hysteresis_and_id_regs #(
    // Arbitrary neutral identity values
    parameter [7:0] MAKER_CODE = 8'h5C,
    parameter [7:0] REVISION_CODE = 8'h2D
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // Host register access
    input wire [7:0] cmd_i,
    input wire wr_en_i,
    input wire [7:0] wr_data_i,
    input wire rd_en_i,
    // Temperatures and limits, one byte per channel
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] temp_i,
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] limit_a_i,
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] limit_b_i,
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] limit_c_i,
    // Event masks, one bit per channel
    input wire [`NUM_CHANNELS-1:0] event_mask_a_i,
    input wire [`NUM_CHANNELS-1:0] event_mask_b_i,
    input wire [`NUM_CHANNELS-1:0] event_mask_c_i,
    // Read answer
    output reg [7:0] rd_data_o,
    output reg rd_valid_o,
    // Per-channel event state and critical pins
    output reg [`NUM_CHANNELS-1:0] event_a_o,
    output reg [`NUM_CHANNELS-1:0] event_b_o,
    output reg [`NUM_CHANNELS-1:0] event_c_o,
    output reg critical_out_a_o,
    output reg critical_out_b_o,
    output reg critical_out_c_o
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg [`HYST_FIELD_W-1:0] hysteresis;
    reg [7:0] next_rd_data;
    wire hyst_write;

    // Only the hysteresis command stores anything; other writes fall away
    assign hyst_write = wr_en_i && (cmd_i == `CMD_COMMON_LIMIT_HYSTERESIS);

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hysteresis <= `HYST_RESET;
        end else if (hyst_write) begin
            hysteresis <= wr_data_i[`HYST_FIELD_MSB:0];
        end
    end

    // ****************************************************************
    // Read decode
    // ****************************************************************
    // Writes to the identifier commands fall through untouched
    always @* begin
        next_rd_data = `READ_IDLE;
        if (cmd_i == `CMD_COMMON_LIMIT_HYSTERESIS) begin
            next_rd_data = {3'h0, hysteresis};
        end else if (cmd_i == `CMD_MAKER_IDENTIFIER) begin
            next_rd_data = MAKER_CODE;
        end else if (cmd_i == `CMD_SILICON_REVISION) begin
            next_rd_data = REVISION_CODE;
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= `READ_IDLE;
        end else if (rd_en_i) begin
            // Data holds between reads so a slow host can fetch it late
            rd_data_o <= next_rd_data;
        end
    end

    // ****************************************************************
    // Read valid pulse
    // ****************************************************************
    // Valid copies the read strobe one edge later and stays high as long as the strobe does
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
        end
    end

    // ****************************************************************
    // Per-channel error events with hysteresis
    // ****************************************************************
    wire [`NUM_CHANNELS-1:0] next_event_a;
    wire [`NUM_CHANNELS-1:0] next_event_b;
    wire [`NUM_CHANNELS-1:0] next_event_c;

    // Each event trips above its limit and, once set, holds until the
    // temperature drops to the limit minus the common hysteresis.
    // One hysteresis value is shared by every channel and every pin.
    // Release is compared at 9 bits so a small limit never wraps below zero
    function trip;
        input [`TEMP_W-1:0] temp;
        input [`TEMP_W-1:0] limit;
        input [`HYST_FIELD_W-1:0] hyst;
        input active;
        reg [`TEMP_W:0] release_lvl;
        begin
            release_lvl = {1'b0, limit} - {4'h0, hyst};
            if (active) begin
                trip = ({1'b0, temp} > release_lvl) ||
                       release_lvl[`TEMP_W];
            end else begin
                trip = temp > limit;
            end
        end
    endfunction

    // ****************************************************************
    // Trip and release per channel
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1) begin : g_chan
            wire [`TEMP_W-1:0] temp_ch;
            assign temp_ch = temp_i[ch*`TEMP_W +: `TEMP_W];
            assign next_event_a[ch] = trip(temp_ch,
                limit_a_i[ch*`TEMP_W +: `TEMP_W], hysteresis, event_a_o[ch]);
            assign next_event_b[ch] = trip(temp_ch,
                limit_b_i[ch*`TEMP_W +: `TEMP_W], hysteresis, event_b_o[ch]);
            assign next_event_c[ch] = trip(temp_ch,
                limit_c_i[ch*`TEMP_W +: `TEMP_W], hysteresis, event_c_o[ch]);
        end
    endgenerate

    // ****************************************************************
    // Unmasked events per output pin
    // ****************************************************************
    // A masked channel still keeps its event state for the host
    wire [`NUM_CHANNELS-1:0] pass_a;
    wire [`NUM_CHANNELS-1:0] pass_b;
    wire [`NUM_CHANNELS-1:0] pass_c;

    assign pass_a = next_event_a & ~event_mask_a_i;
    assign pass_b = next_event_b & ~event_mask_b_i;
    assign pass_c = next_event_c & ~event_mask_c_i;

    // ****************************************************************
    // Output a: events and critical pin
    // ****************************************************************
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_a_o <= {`NUM_CHANNELS{1'b0}};
            critical_out_a_o <= 1'b0;
        end else begin
            event_a_o <= next_event_a;
            // Pin moves on the same edge as the event it reflects
            critical_out_a_o <= |pass_a;
        end
    end

    // ****************************************************************
    // Output b: events and critical pin
    // ****************************************************************
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_b_o <= {`NUM_CHANNELS{1'b0}};
            critical_out_b_o <= 1'b0;
        end else begin
            event_b_o <= next_event_b;
            critical_out_b_o <= |pass_b;
        end
    end

    // ****************************************************************
    // Output c: events and critical pin
    // ****************************************************************
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_c_o <= {`NUM_CHANNELS{1'b0}};
            critical_out_c_o <= 1'b0;
        end else begin
            event_c_o <= next_event_c;
            critical_out_c_o <= |pass_c;
        end
    end

endmodule // tcrit_hysteresis_and_id_regs

/* File: pkg/tcrit_hyst_id_defines.vh */
// Command bytes, field layouts and reset values of the hysteresis/ID bank
`ifndef TCRIT_HYST_ID_DEFINES_VH
`define TCRIT_HYST_ID_DEFINES_VH
`define CMD_COMMON_LIMIT_HYSTERESIS 8'h5A
`define CMD_MAKER_IDENTIFIER 8'hFE
`define CMD_SILICON_REVISION 8'hFF
`define HYST_FIELD_MSB 4
`define HYST_FIELD_W 5
`define HYST_RESET 5'h0A
`define NUM_CHANNELS 5
`define NUM_OUTPUTS 3
`define TEMP_W 8
`define READ_IDLE 8'h00
`endif

/* File: dv/tcrit_regs_checker.sv */
// Port assertions for the hysteresis and identification bank
`timescale 1ns/1ps
`include "tcrit_hyst_id_defines.vh"
module tcrit_regs_checker (
    input wire ref_clk_i,
    input wire rst_i,
    input wire [7:0] cmd_i,
    input wire wr_en_i,
    input wire [7:0] wr_data_i,
    input wire rd_en_i,
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] temp_i,
    input wire [`NUM_CHANNELS*`TEMP_W-1:0] limit_a_i,
    input wire [7:0] rd_data_o,
    input wire rd_valid_o,
    input wire [`NUM_CHANNELS-1:0] event_a_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr;
        wr_en_i && cmd_i == 8'h5A ##1 !wr_en_i ##1
        rd_en_i && cmd_i == 8'h5A && !wr_en_i;
    endsequence
    property p_vld; rd_en_i |=> rd_valid_o ##1 rd_valid_o == $past(rd_en_i); endproperty
    a_vld: assert property (p_vld) else $error("valid");
    property p_hz; rd_en_i && cmd_i == 8'h5A |=> rd_data_o[7:5] == 3'b000; endproperty
    a_hz: assert property (p_hz) else $error("upper bits");
    property p_wr; s_wr |=> rd_data_o == (8'h1F & $past(wr_data_i, 3)); endproperty
    a_wr: assert property (p_wr) else $error("hysteresis field");
    property p_mk; rd_en_i && cmd_i == 8'hFE |=> rd_data_o == 8'h5C; endproperty
    a_mk: assert property (p_mk) else $error("maker");
    property p_rv; rd_en_i && cmd_i == 8'hFF |=> rd_data_o == 8'h2D; endproperty
    a_rv: assert property (p_rv) else $error("revision");
    property p_un; rd_en_i && cmd_i != 8'h5A && cmd_i < 8'hFE |=> !rd_data_o; endproperty
    a_un: assert property (p_un) else $error("unmapped");
    property p_tr; temp_i[7:0] > limit_a_i[7:0] |=> event_a_o[0]; endproperty
    a_tr: assert property (p_tr) else $error("trip");
    property p_rl; $fell(event_a_o[0]) |-> $past(temp_i[7:0]) <= $past(limit_a_i[7:0]); endproperty
    a_rl: assert property (p_rl) else $error("release");
endmodule // tcrit_regs_checker
bind tcrit_hysteresis_and_id_regs tcrit_regs_checker chk_i (.*);

/* File: dv/smbus_host_model.sv */
// Host model issuing single-byte register writes and reads
`timescale 1ns/1ps
module smbus_host_model (
    input wire ref_clk_i,
    input wire [7:0] rd_data_o,
    input wire rd_valid_o,
    output logic [7:0] cmd_i = 8'h00,
    output logic wr_en_i = 1'b0,
    output logic [7:0] wr_data_i = 8'h00,
    output logic rd_en_i = 1'b0
);
    task wr(input [7:0] c, input [7:0] dt);
        @(posedge ref_clk_i);
        cmd_i <= c;
        wr_data_i <= dt;
        wr_en_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_en_i <= 1'b0;
        // Released data shows no stale byte
        wr_data_i <= ~dt;
    endtask
    task rd(input [7:0] c, output [7:0] dt, output v);
        @(posedge ref_clk_i);
        cmd_i <= c;
        rd_en_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_en_i <= 1'b0;
        #1;
        v = rd_valid_o;
        dt = rd_data_o;
    endtask
endmodule // smbus_host_model

/* File: dv/tcrit_hysteresis_and_id_regs_tb_top.sv */
// Self-checking bench for the hysteresis and identification bank
`timescale 1ns/1ps
module tcrit_hysteresis_and_id_regs_tb_top;
    logic ref_clk_i = 0, rst_i = 1, v, wr_en_i, rd_en_i, rd_valid_o;
    logic [7:0] cmd_i, wr_data_i, rd_data_o, d;
    logic [39:0] t = 0, l = {5{8'h50}};
    logic [4:0] m = 0, e, eb, ec;
    logic [2:0] c;
    int fails = 0, total_checks = 0;
    smbus_host_model h (.*);
    tcrit_hysteresis_and_id_regs dut (.ref_clk_i, .rst_i, .cmd_i, .wr_en_i,
        .wr_data_i, .rd_en_i, .temp_i(t), .limit_a_i(l), .limit_b_i(l),
        .limit_c_i(l), .event_mask_a_i(m), .event_mask_b_i(m),
        .event_mask_c_i(m), .rd_data_o, .rd_valid_o, .event_a_o(e),
        .event_b_o(eb), .event_c_o(ec), .critical_out_a_o(c[0]),
        .critical_out_b_o(c[1]), .critical_out_c_o(c[2]));
    task chk(string n, logic [7:0] x, logic [7:0] g);
        total_checks++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, x, g);
        end
    endtask
    task rdc(logic [7:0] a, logic [7:0] x);
        h.rd(a, d, v);
        chk("valid", 8'h01, {7'h00, v});
        chk("rd_data", x, d);
    endtask
    task t_regs;
        rdc(8'h5A, 8'h0A);
        h.wr(8'h5A, 8'hFF);
        rdc(8'h5A, 8'h1F);
        h.wr(8'hFE, 8'h00);
        rdc(8'hFE, 8'h5C);
        rdc(8'hFF, 8'h2D);
        rdc(8'h5B, 8'h00);
        h.wr(8'h5A, 8'h04);
    endtask
    task st(logic [7:0] tt, logic [4:0] mm, logic [7:0] xe, logic [7:0] xc);
        @(posedge ref_clk_i);
        t[7:0] <= tt;
        m <= mm;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("event", xe, {3'b000, e});
        chk("event_b", xe, {3'b000, eb});
        chk("event_c", xe, {3'b000, ec});
        chk("critical", xc, {5'h00, c});
    endtask
    task t_evt;
        st(8'h51, 5'h00, 8'h01, 8'h07);
        st(8'h4D, 5'h00, 8'h01, 8'h07);
        st(8'h4C, 5'h00, 8'h00, 8'h00);
        st(8'h51, 5'h01, 8'h01, 8'h00);
    endtask
    task results;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial forever #10 ref_clk_i = ~ref_clk_i;
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_evt;
        results;
    end
    initial begin
        #20000;
        fails++;
        results;
    end
endmodule // tcrit_hysteresis_and_id_regs_tb_top
